// File: rtl/embi_consts.svh
`ifndef EMBI_CONSTS_SVH
`define EMBI_CONSTS_SVH
// Bus and field widths, data zone count
`define EMBI_ADDR_W      14
`define EMBI_DATA_W      24
`define EMBI_WORD_W      16
`define EMBI_PX_W        8
`define EMBI_WAIT_W      3
`define EMBI_ZONES_MAX   5
// Wait-state count loaded on reset
`define EMBI_WAIT_RESET  3'h7
// Variant codes
`define EMBI_VAR_12K     0
`define EMBI_VAR_8K      1
`define EMBI_VAR_4K      2
// Program memory map boundaries
`define EMBI_PM_LOW_EXT_END  14'h0800
`define EMBI_PM_ROM4K_END    14'h1000
`define EMBI_PM_ROM8K_END    14'h2000
`define EMBI_PM_RAM_BASE     14'h3000
`define EMBI_PM_HIGH_BASE    14'h3800
// Data memory map boundaries
`define EMBI_DM_RAM4K_BASE   14'h2000
`define EMBI_DM_RAM512_BASE  14'h3800
// External data zone boundaries
`define EMBI_DZ1_BASE        14'h0800
`define EMBI_DZ2_BASE        14'h1000
`define EMBI_DZ3_BASE        14'h2000
`define EMBI_DZ4_BASE        14'h3000
`endif

// File: rtl/embi_pkg.sv
`include "embi_consts.svh"
package embi_pkg;
  // Sequencer of the external bus
  typedef enum logic [1:0] {
    EMBI_IDLE   = 2'b00,
    EMBI_ACCESS = 2'b01,
    EMBI_GRANT  = 2'b10
  } embi_state_t;
  // One access request from the core
  typedef struct packed {
    logic                      valid;  // Request present
    logic                      prog;   // Program space, else data space
    logic                      fetch;  // Full 24-bit instruction fetch
    logic                      write;  // Write, else read
    logic [`EMBI_ADDR_W-1:0]   addr;   // Word address
    logic [`EMBI_WORD_W-1:0]   wdata;  // 16-bit register value
  } embi_req_t;
  // Wait-state configuration load from the core
  typedef struct packed {
    logic                      pm_set;  // Load program wait count
    logic                      dm_set;  // Load one data zone count
    logic [2:0]                zone;    // Zone index for dm_set
    logic [`EMBI_WAIT_W-1:0]   value;   // New count
  } embi_wcfg_t;
  // Whole state of the interface
  typedef struct packed {
    embi_state_t                                st;
    logic [`EMBI_WAIT_W-1:0]                    cnt;
    logic [`EMBI_ADDR_W-1:0]                    addr;
    logic [`EMBI_DATA_W-1:0]                    wdata;
    logic [`EMBI_DATA_W-1:0]                    rdata;
    logic                                       prog;
    logic                                       fetch;
    logic                                       write;
    logic                                       pms_n;
    logic                                       dms_n;
    logic                                       rd_n;
    logic                                       wr_n;
    logic                                       done;
    logic                                       internal;
    logic [`EMBI_PX_W-1:0]                      px;
    logic [`EMBI_WAIT_W-1:0]                    pm_wait;
    logic [`EMBI_ZONES_MAX-1:0][`EMBI_WAIT_W-1:0] dm_wait;
  } embi_regs_t;
endpackage

// File: rtl/embi_top.sv
`include "embi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module embi_top #(
  parameter int VARIANT = `EMBI_VAR_12K
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     map_select,
  input  wire logic                     go_mode,
  input  wire logic                     bus_request_n,
  input  wire embi_pkg::embi_req_t      acc_req,
  output logic                          acc_ready,
  output logic                          core_halt,
  output logic                          acc_done,
  output logic                          acc_internal,
  output logic [`EMBI_DATA_W-1:0]       acc_rdata,
  output logic [`EMBI_WORD_W-1:0]       acc_rdata_word,
  input  wire embi_pkg::embi_wcfg_t     wait_cfg,
  input  wire logic                     px_load,
  input  wire logic [`EMBI_PX_W-1:0]    px_wdata,
  output logic [`EMBI_PX_W-1:0]         prog_extension_reg,
  output logic [`EMBI_ADDR_W-1:0]       addr_out,
  output logic                          addr_oe_n,
  input  wire logic [`EMBI_DATA_W-1:0]  data_in,
  output logic [`EMBI_DATA_W-1:0]       data_out,
  output logic                          data_oe_n,
  output logic                          prog_mem_select_n,
  output logic                          data_mem_select_n,
  output logic                          boot_mem_select_n,
  output logic                          rd_n,
  output logic                          wr_n,
  output logic                          ctrl_oe_n,
  output logic                          bus_grant_n
);

  // Zones actually decoded by this variant
  localparam int ZONES = (VARIANT == `EMBI_VAR_12K) ? 3 : 5;

  // Refuse variant codes the decoders do not know
  generate
    if (VARIANT < `EMBI_VAR_12K || VARIANT > `EMBI_VAR_4K) begin : g_bad_variant
      $error("embi_top: VARIANT must be 0, 1 or 2");
    end
  endgenerate

  embi_pkg::embi_regs_t s;       // Registered state
  embi_pkg::embi_regs_t next_s;  // Next state
  logic                 req_ext; // Current request leaves the chip
  logic [2:0]           req_zone;

  // Program address goes off-chip for this variant and map
  function automatic logic prog_is_ext(input logic [`EMBI_ADDR_W-1:0] a,
                                       input logic                    mm);
    logic r;
    r = 1'b0;
    case (VARIANT)
      `EMBI_VAR_12K: begin
        if (!mm) begin
          r = (a >= `EMBI_PM_HIGH_BASE);
        end else begin
          r = (a < `EMBI_PM_LOW_EXT_END);
        end
      end
      `EMBI_VAR_8K: begin
        if (!mm) begin
          r = (a >= `EMBI_PM_ROM8K_END);
        end else begin
          // High map: low 2K and the middle block above the ROM
          r = (a < `EMBI_PM_LOW_EXT_END) ||
              (a >= `EMBI_PM_ROM8K_END && a < `EMBI_PM_HIGH_BASE);
        end
      end
      default: begin
        if (!mm) begin
          r = (a >= `EMBI_PM_ROM4K_END);
        end else begin
          r = (a < `EMBI_PM_LOW_EXT_END) ||
              (a >= `EMBI_PM_ROM4K_END && a < `EMBI_PM_HIGH_BASE);
        end
      end
    endcase
    return r;
  endfunction

  // Data address goes off-chip; on-chip RAM and control space stay in
  function automatic logic data_is_ext(input logic [`EMBI_ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    if (VARIANT == `EMBI_VAR_12K) begin
      r = (a < `EMBI_DM_RAM4K_BASE);
    end else begin
      r = (a < `EMBI_DM_RAM512_BASE);
    end
    return r;
  endfunction

  // Wait-state zone of an external data address
  function automatic logic [2:0] data_zone(input logic [`EMBI_ADDR_W-1:0] a);
    logic [2:0] z;
    z = 3'h0;
    if (a >= `EMBI_DZ4_BASE) begin
      z = 3'h4;
    end else if (a >= `EMBI_DZ3_BASE) begin
      z = 3'h3;
    end else if (a >= `EMBI_DZ2_BASE) begin
      z = 3'h2;
    end else if (a >= `EMBI_DZ1_BASE) begin
      z = 3'h1;
    end
    return z;
  endfunction

  // Decode of the request now on the core port
  always_comb begin
    req_ext  = acc_req.prog ? prog_is_ext(acc_req.addr, map_select)
                            : data_is_ext(acc_req.addr);
    req_zone = data_zone(acc_req.addr);
  end

  // Ready: idle with no bus request, or granted in continue mode
  // for an access that stays on-chip
  always_comb begin
    acc_ready = ((s.st == embi_pkg::EMBI_IDLE) && bus_request_n) ||
                ((s.st == embi_pkg::EMBI_GRANT) && go_mode && !req_ext);
    core_halt = acc_req.valid && !acc_ready;
  end

  // Next-state logic
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;

    // Wait-state configuration; out-of-range zones are ignored
    if (wait_cfg.pm_set) begin
      next_s.pm_wait = wait_cfg.value;
    end
    if (wait_cfg.dm_set && (int'(wait_cfg.zone) < ZONES)) begin
      next_s.dm_wait[wait_cfg.zone] = wait_cfg.value;
    end
    // Direct extension register load from the core
    if (px_load) begin
      next_s.px = px_wdata;
    end

    case (s.st)
      embi_pkg::EMBI_IDLE: begin
        if (!bus_request_n) begin
          // Grant beats a new access; outputs float next cycle
          next_s.st = embi_pkg::EMBI_GRANT;
        end else if (acc_req.valid) begin
          if (req_ext) begin
            next_s.st    = embi_pkg::EMBI_ACCESS;
            next_s.addr  = acc_req.addr;
            next_s.prog  = acc_req.prog;
            next_s.fetch = acc_req.fetch;
            next_s.write = acc_req.write;
            // Program words get the extension byte low,
            // data words sit on the upper lines
            next_s.wdata = acc_req.prog ? {acc_req.wdata, s.px}
                                        : {acc_req.wdata, 8'h00};
            next_s.cnt   = acc_req.prog ? s.pm_wait : s.dm_wait[req_zone];
            next_s.pms_n = !acc_req.prog;
            next_s.dms_n = acc_req.prog;
            next_s.rd_n  = acc_req.write;
            next_s.wr_n  = !acc_req.write;
          end else begin
            // On-chip target: answered at once, pins untouched
            next_s.done     = 1'b1;
            next_s.internal = 1'b1;
          end
        end
      end
      embi_pkg::EMBI_ACCESS: begin
        if (s.cnt != 3'h0) begin
          // Strobe, select and address hold through each wait
          next_s.cnt = s.cnt - 3'h1;
        end else begin
          next_s.pms_n    = 1'b1;
          next_s.dms_n    = 1'b1;
          next_s.rd_n     = 1'b1;
          next_s.wr_n     = 1'b1;
          next_s.done     = 1'b1;
          next_s.internal = 1'b0;
          if (!s.write) begin
            next_s.rdata = data_in;
            if (s.prog && !s.fetch) begin
              next_s.px = data_in[`EMBI_PX_W-1:0];
            end
          end
          // A pending request is granted only after completion
          next_s.st = bus_request_n ? embi_pkg::EMBI_IDLE
                                    : embi_pkg::EMBI_GRANT;
        end
      end
      embi_pkg::EMBI_GRANT: begin
        if (bus_request_n) begin
          // Master let go: drive again and resume
          next_s.st = embi_pkg::EMBI_IDLE;
        end else if (acc_req.valid && go_mode && !req_ext) begin
          next_s.done     = 1'b1;
          next_s.internal = 1'b1;
        end
      end
      default: begin
        next_s.st = embi_pkg::EMBI_IDLE;
      end
    endcase

    // Reset defaults; a request held during reset is still granted
    if (rst) begin
      next_s.st       = bus_request_n ? embi_pkg::EMBI_IDLE
                                      : embi_pkg::EMBI_GRANT;
      next_s.cnt      = 3'h0;
      next_s.addr     = 14'h0000;
      next_s.wdata    = 24'h00_0000;
      next_s.rdata    = 24'h00_0000;
      next_s.prog     = 1'b0;
      next_s.fetch    = 1'b0;
      next_s.write    = 1'b0;
      next_s.pms_n    = 1'b1;
      next_s.dms_n    = 1'b1;
      next_s.rd_n     = 1'b1;
      next_s.wr_n     = 1'b1;
      next_s.done     = 1'b0;
      next_s.internal = 1'b0;
      next_s.px       = 8'h00;
      next_s.pm_wait  = `EMBI_WAIT_RESET;
      for (int i = 0; i < `EMBI_ZONES_MAX; i++) begin
        next_s.dm_wait[i] = `EMBI_WAIT_RESET;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // Pin and core outputs, all from the state register but the tied-off boot select
  always_comb begin
    acc_done           = s.done;
    acc_internal       = s.internal;
    acc_rdata          = s.rdata;
    acc_rdata_word     = s.rdata[`EMBI_DATA_W-1:`EMBI_PX_W];
    prog_extension_reg = s.px;
    addr_out           = s.addr;
    data_out           = s.wdata;
    prog_mem_select_n  = s.pms_n;
    data_mem_select_n  = s.dms_n;
    boot_mem_select_n  = 1'b1;  // No boot memory on this part
    rd_n               = s.rd_n;
    wr_n               = s.wr_n;
    // Address and control drivers float only while granted
    addr_oe_n          = (s.st == embi_pkg::EMBI_GRANT);
    ctrl_oe_n          = (s.st == embi_pkg::EMBI_GRANT);
    bus_grant_n        = (s.st != embi_pkg::EMBI_GRANT);
    // Data lines driven only during an external write
    data_oe_n          = !((s.st == embi_pkg::EMBI_ACCESS) && s.write);
  end

endmodule
`default_nettype wire

// File: tb/embi_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the external bus interface
module embi_monitor (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 bus_request_n,
  input wire embi_pkg::embi_wcfg_t wait_cfg,
  input wire logic                 acc_done,
  input wire logic [7:0]           prog_extension_reg,
  input wire logic [13:0]          addr_out,
  input wire logic [23:0]          data_out,
  input wire logic                 addr_oe_n,
  input wire logic                 data_oe_n,
  input wire logic                 ctrl_oe_n,
  input wire logic                 prog_mem_select_n,
  input wire logic                 data_mem_select_n,
  input wire logic                 rd_n,
  input wire logic                 wr_n,
  input wire logic                 bus_grant_n
);
  logic [3:0] strobe_len; // Strobe-low cycles of the current access
  logic [2:0] pm_w;       // Shadow of the program wait count
  // The wait count is hidden inside, so it is rebuilt from the config port
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_len <= 4'h0;
      pm_w       <= 3'h7;
    end else begin
      strobe_len <= (rd_n && wr_n) ? 4'h0 : strobe_len + 4'h1;
      if (wait_cfg.pm_set) begin
        pm_w <= wait_cfg.value;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  grant_release_a: assert property (!bus_grant_n |-> addr_oe_n && data_oe_n && ctrl_oe_n)
    else $error("drivers on while granted");
  grant_hold_a: assert property (!bus_request_n && !bus_grant_n |=> !bus_grant_n)
    else $error("grant dropped early");
  grant_late_a: assert property ($fell(bus_request_n) |-> ##[1:9] !bus_grant_n)
    else $error("grant too late");
  grant_return_a: assert property (bus_request_n && !bus_grant_n |=> bus_grant_n)
    else $error("grant kept after release");
  one_select_a: assert property (!(rd_n && wr_n) |-> prog_mem_select_n != data_mem_select_n)
    else $error("select wrong during strobe");
  write_drive_a: assert property (!wr_n |-> rd_n && !data_oe_n)
    else $error("write strobe without data drive");
  strobe_stable_a: assert property (!rd_n && !$past(rd_n) |->
      $stable(addr_out) && $stable(prog_mem_select_n))
    else $error("address moved in strobe");
  data_low_a: assert property (!wr_n && !data_mem_select_n |-> data_out[7:0] == 8'h00)
    else $error("data low byte not zero");
  px_low_a: assert property (!wr_n && !prog_mem_select_n |-> data_out[7:0] == prog_extension_reg)
    else $error("program low byte not extension");
  pm_wait_a: assert property ($rose(rd_n && wr_n) && !$past(prog_mem_select_n) |->
      strobe_len == {1'b0, pm_w} + 4'h1)
    else $error("program strobe length wrong");
  done_end_a: assert property ($rose(rd_n && wr_n) |-> acc_done)
    else $error("no done after strobe");
endmodule
bind embi_top embi_monitor embi_monitor_inst (
  .clk(clk), .rst(rst), .bus_request_n(bus_request_n), .wait_cfg(wait_cfg),
  .acc_done(acc_done), .prog_extension_reg(prog_extension_reg), .addr_out(addr_out),
  .data_out(data_out), .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n), .ctrl_oe_n(ctrl_oe_n),
  .prog_mem_select_n(prog_mem_select_n), .data_mem_select_n(data_mem_select_n),
  .rd_n(rd_n), .wr_n(wr_n), .bus_grant_n(bus_grant_n)
);
`default_nettype wire

// File: tb/embi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural external memory on the far side of the pins
module embi_mem_model (
  input wire logic        clk,
  input wire logic [13:0] addr_out,
  input wire logic [23:0] data_out,
  input wire logic        sel_n,   // Any select low and pins driven
  input wire logic        rd_n,
  input wire logic        wr_n,
  output logic [23:0]     data_in
);
  logic [23:0] mem [64];            // Small array; upper address bits alias
  logic [23:0] last = 24'h5a_5a5a;  // Last value put on the bus
  // Latch write data on the write strobe
  always_ff @(posedge clk) begin
    if (!sel_n && !wr_n) begin
      mem[addr_out[5:0]] <= data_out;
    end
    if (!sel_n && !rd_n) begin
      last <= mem[addr_out[5:0]];
    end
  end
  // Released bus shows the inverse, so stale data never looks valid
  always_comb begin
    data_in = (!sel_n && !rd_n) ? mem[addr_out[5:0]] : ~last;
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the external memory bus interface
module testbench;
  typedef struct {int lat; int t0; logic intl; logic chk; logic [15:0] word;} embi_exp_t;
  logic                 clk = 1'b0, rst = 1'b1, map_select = 1'b0, go_mode = 1'b0;
  logic                 bus_request_n = 1'b1; // Held inactive when unused
  logic                 px_load = 1'b0;
  logic [7:0]           px_wdata = 8'h00, px_reg;
  embi_pkg::embi_req_t  acc_req = '0;
  embi_pkg::embi_wcfg_t wait_cfg = '0;
  logic                 acc_ready, core_halt, acc_done, acc_internal, addr_oe_n, data_oe_n;
  logic                 ctrl_oe_n, pms_n, dms_n, bms_n, rd_n, wr_n, bus_grant_n;
  logic [23:0]          acc_rdata, data_in, data_out;
  logic [15:0]          acc_rdata_word, rw;
  logic [13:0]          addr_out;
  embi_exp_t            exp_q[$], e;
  int                   failures = 0, n_tests = 0, cyc = 0, seed = 32'h3eca_f9d6;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  embi_top embi_top_inst (.clk(clk), .rst(rst), .map_select(map_select), .go_mode(go_mode),
    .bus_request_n(bus_request_n), .acc_req(acc_req), .acc_ready(acc_ready),
    .core_halt(core_halt), .acc_done(acc_done), .acc_internal(acc_internal),
    .acc_rdata(acc_rdata), .acc_rdata_word(acc_rdata_word), .wait_cfg(wait_cfg),
    .px_load(px_load), .px_wdata(px_wdata), .prog_extension_reg(px_reg), .addr_out(addr_out),
    .addr_oe_n(addr_oe_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .prog_mem_select_n(pms_n), .data_mem_select_n(dms_n), .boot_mem_select_n(bms_n),
    .rd_n(rd_n), .wr_n(wr_n), .ctrl_oe_n(ctrl_oe_n), .bus_grant_n(bus_grant_n));
  embi_mem_model embi_mem_model_inst (.clk(clk), .addr_out(addr_out), .data_out(data_out),
    .sel_n((pms_n & dms_n) | ctrl_oe_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
  task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      $display("Error %s expected %h seen %h", name, expv, seen);
      failures++;
    end
  endtask
  task automatic print_verdict();
    $display("Tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait for a level, looked at just after the falling edge
  task automatic wait_for(ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val) begin
      @(negedge clk);
      #1;
      n++;
      if (n > 40) begin
        failures++;
        print_verdict();
      end
    end
  endtask
  // One core access; the note goes in the queue just before the edge that takes it
  task automatic acc(logic p, logic w, logic [13:0] a, logic [15:0] d, int lat, logic intl,
                     logic chk);
    @(negedge clk);
    acc_req = '{valid: 1'b1, prog: p, fetch: 1'b0, write: w, addr: a, wdata: d};
    #1;
    wait_for(acc_ready, 1'b1);
    exp_q.push_back('{lat, cyc, intl, chk, d});
    @(negedge clk);
    acc_req.valid = 1'b0;
    wait_for(acc_done, 1'b1);
  endtask
  task automatic set_px(logic [7:0] v);
    @(negedge clk);
    px_wdata = v;
    px_load = 1'b1;
    @(negedge clk);
    px_load = 1'b0;
  endtask
  task automatic set_wait(logic pm, logic [2:0] z, logic [2:0] v);
    @(negedge clk);
    wait_cfg = '{pm_set: pm, dm_set: !pm, zone: z, value: v};
    @(negedge clk);
    wait_cfg = '0;
  endtask
  // Takes the oldest note whenever a completion shows
  always @(negedge clk) begin
    #2;
    if (acc_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spurious done", 1, 0);
      end else begin
        e = exp_q.pop_front();
        check("latency", cyc - e.t0, e.lat);
        check("internal", acc_internal, e.intl);
        if (e.chk) check("read word", acc_rdata_word, e.word);
      end
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Program waits swept with random data; extension byte round trip
    for (int w = 7; w >= 0; w -= 3) begin
      if (w < 7) set_wait(1'b1, 3'h0, w[2:0]);
      rw = 16'($random(seed));
      set_px(rw[7:0]);
      acc(1'b1, 1'b1, 14'h3801, rw, w + 2, 1'b0, 1'b0);
      set_px(8'h00);
      acc(1'b1, 1'b0, 14'h3801, rw, w + 2, 1'b0, 1'b1);
      check("px", px_reg, rw[7:0]);
      check("raw low byte", acc_rdata[7:0], rw[7:0]);
      check("boot select", bms_n, 1'b1);
    end
    // On-chip targets are acknowledged without pin activity, then one high-map low-block program write goes off-chip
    acc(1'b1, 1'b0, 14'h0000, 16'h0000, 1, 1'b1, 1'b0);
    acc(1'b0, 1'b0, 14'h2000, 16'h0000, 1, 1'b1, 1'b0);
    acc(1'b0, 1'b1, 14'h3fff, 16'h0000, 1, 1'b1, 1'b0);
    map_select = 1'b1;
    acc(1'b1, 1'b0, 14'h3000, 16'h0000, 1, 1'b1, 1'b0);
    acc(1'b1, 1'b0, 14'h3900, 16'h0000, 1, 1'b1, 1'b0);
    acc(1'b1, 1'b1, 14'h0005, 16'hbeef, 3, 1'b0, 1'b0);
    map_select = 1'b0;
    // Zone one shortened, zones zero and two keep the reset count
    set_wait(1'b0, 3'h1, 3'h2);
    acc(1'b0, 1'b1, 14'h0810, 16'hc3a5, 4, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 14'h0810, 16'hc3a5, 4, 1'b0, 1'b1);
    acc(1'b0, 1'b1, 14'h0020, 16'h5a0f, 9, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 14'h1020, 16'h5a0f, 9, 1'b0, 1'b1);
    // Idle request: grant next cycle, core halts except for on-chip accesses in go mode
    @(negedge clk);
    bus_request_n = 1'b0;
    @(negedge clk);
    #1;
    check("grant", {bus_grant_n, addr_oe_n, data_oe_n, ctrl_oe_n}, 4'h7);
    acc_req = '{valid: 1'b1, prog: 1'b1, fetch: 1'b0, write: 1'b0, addr: 14'h0, wdata: 16'h0};
    #1;
    check("halt", {acc_ready, core_halt}, 2'b01);
    acc_req.valid = 1'b0;
    go_mode = 1'b1;
    acc(1'b1, 1'b0, 14'h0000, 16'h0000, 1, 1'b1, 1'b0);
    acc_req = '{valid: 1'b1, prog: 1'b1, fetch: 1'b0, write: 1'b0, addr: 14'h3800, wdata: 16'h0};
    #1;
    check("go stall", acc_ready, 1'b0);
    acc_req.valid = 1'b0;
    go_mode = 1'b0;
    bus_request_n = 1'b1;
    @(negedge clk);
    #1;
    check("ungrant", {bus_grant_n, ctrl_oe_n}, 2'b10);
    // Request in mid-access waits for the access to end
    fork
      acc(1'b1, 1'b0, 14'h3801, rw, 3, 1'b0, 1'b1);
      begin
        // One edge after the access is taken, so the request lands mid-access
        repeat (2) @(negedge clk);
        bus_request_n = 1'b0;
      end
    join
    wait_for(bus_grant_n, 1'b0);
    bus_request_n = 1'b1;
    wait_for(bus_grant_n, 1'b1);
    // Request honoured while reset is held; waits back to seven after
    rst = 1'b1;
    bus_request_n = 1'b0;
    repeat (2) @(negedge clk);
    check("reset grant", bus_grant_n, 1'b0);
    rst = 1'b0;
    bus_request_n = 1'b1;
    wait_for(bus_grant_n, 1'b1);
    acc(1'b1, 1'b0, 14'h3801, rw, 9, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    check("queue left", exp_q.size(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
